// ---- hdl/iep_ctrl.sv ----
// interrupt enable, priority and arbitration for the first seven sources
`timescale 1ns/1ps
module iep_ctrl (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   output logic [7:0] sfr_rdata,
   // pending flags, same clock domain
   input wire logic ext_line_zero_input,
   input wire logic timer_zero_overflow,
   input wire logic ext_line_one_input,
   input wire logic timer_one_overflow,
   input wire logic uart_pending,
   input wire logic timer_two_low_overflow,
   input wire logic timer_two_high_overflow,
   input wire logic spi_pending,
   // cpu handshake
   input wire logic isr_enter,
   input wire logic isr_return,
   output logic irq_req,
   output logic [2:0] irq_src,
   output logic [1:0] irq_level
);
   // mask register, bit 7 is the global gate
   logic [7:0] interrupt_mask_reg;
   logic [7:0] interrupt_mask_next;
   // priority bits, bit 7 not stored
   logic [6:0] priority_low_bits_reg;
   logic [6:0] priority_low_bits_next;
   logic [6:0] priority_high_bits_reg;
   logic [6:0] priority_high_bits_next;
   // active-service stack of levels, one bit per level
   logic [3:0] active_reg;
   logic [3:0] active_next;
   // registered outputs
   logic irq_req_reg;
   logic [2:0] irq_src_reg;
   logic [1:0] irq_level_reg;

   // address decode
   wire sel_mask = (sfr_addr == iep_pkg::ADDR_MASK);
   wire sel_lo = (sfr_addr == iep_pkg::ADDR_PRIO_LO);
   wire sel_hi = (sfr_addr == iep_pkg::ADDR_PRIO_HI);

   // byte write merged with single-bit write; byte strobe wins
   // every input is an argument: a continuous assignment only wakes
   // on its arguments, so a strobe read from the module would go stale
   function automatic logic [7:0] merge(input logic [7:0] cur,
                                        input logic sel,
                                        input logic byte_we,
                                        input logic [7:0] byte_val,
                                        input logic bit_we,
                                        input logic [2:0] bit_idx,
                                        input logic bit_val);
      logic [7:0] v; // merged value
      v = cur;
      if (sel && byte_we) begin
         // whole byte replaced
         v = byte_val;
      end else if (sel && bit_we) begin
         // read-modify-write of one bit
         v[bit_idx] = bit_val;
      end
      return v;
   endfunction : merge

   // next values of the three registers, bit 7 padded where not stored
   wire [7:0] mask_w = merge(interrupt_mask_reg, sel_mask, sfr_wr,
      sfr_wdata, sfr_bit_wr, sfr_bit_sel, sfr_bit_val);
   wire [7:0] lo_w = merge({1'b0, priority_low_bits_reg}, sel_lo, sfr_wr,
      sfr_wdata, sfr_bit_wr, sfr_bit_sel, sfr_bit_val);
   wire [7:0] hi_w = merge({1'b0, priority_high_bits_reg}, sel_hi, sfr_wr,
      sfr_wdata, sfr_bit_wr, sfr_bit_sel, sfr_bit_val);
   // bit 7 dropped on write to the priority registers; the mask keeps all eight bits
   assign interrupt_mask_next = mask_w;
   assign priority_low_bits_next = lo_w[6:0];
   assign priority_high_bits_next = hi_w[6:0];

   // read mux; unmapped addresses read zero
   // combinational so the core sees data in its access cycle
   assign sfr_rdata = sel_mask ? interrupt_mask_reg :
      sel_lo ? {iep_pkg::UNUSED_READ, priority_low_bits_reg} :
      sel_hi ? {iep_pkg::UNUSED_READ, priority_high_bits_reg} :
      8'h00;

   // raw pending per source in fixed order 0..6
   wire [6:0] pend;
   assign pend[0] = ext_line_zero_input;
   assign pend[1] = timer_zero_overflow;
   assign pend[2] = ext_line_one_input;
   assign pend[3] = timer_one_overflow;
   assign pend[4] = uart_pending;
   assign pend[5] = timer_two_low_overflow | timer_two_high_overflow;

   assign pend[6] = spi_pending;

   // named mask bits, placed by the package field positions
   wire global_irq_gate = interrupt_mask_reg[iep_pkg::BIT_GLOBAL];
   wire serial_periph_irq_mask = interrupt_mask_reg[iep_pkg::BIT_SPI];
   wire timer_two_irq_mask = interrupt_mask_reg[iep_pkg::BIT_TMR2];
   wire async_serial_irq_mask = interrupt_mask_reg[iep_pkg::BIT_UART];
   wire timer_one_irq_mask = interrupt_mask_reg[iep_pkg::BIT_TMR1];
   wire ext_line_one_irq_mask = interrupt_mask_reg[iep_pkg::BIT_EXT1];
   wire timer_zero_irq_mask = interrupt_mask_reg[iep_pkg::BIT_TMR0];
   wire ext_line_zero_irq_mask = interrupt_mask_reg[iep_pkg::BIT_EXT0];
   // per-source masks in the fixed source order 0..6
   wire [6:0] src_mask = {serial_periph_irq_mask, timer_two_irq_mask,
      async_serial_irq_mask, timer_one_irq_mask, ext_line_one_irq_mask,
      timer_zero_irq_mask, ext_line_zero_irq_mask};
   wire [6:0] gated; // pending, masked and globally enabled
   wire [1:0] lvl [7];
   // per-source gating and level assembly
   genvar g;
   generate
      for (g = 0; g < iep_pkg::NUM_SRC; g++) begin : g_src
         // mask bits sit at the source index
         assign gated[g] = pend[g] & src_mask[g]
            & global_irq_gate;
         assign lvl[g] = {priority_high_bits_reg[g],
                          priority_low_bits_reg[g]};
      end
   endgenerate

   // current running level; run_any low means no routine in service
   // run_lvl is the highest level whose routine is still active
   wire run_any = |active_reg; // any routine in service
   logic [1:0] run_lvl;
   always_comb begin
      run_lvl = 2'h0;
      for (int i = 0; i < iep_pkg::STACK_D; i++) begin
         if (active_reg[i]) run_lvl = i[1:0];
      end
   end

   // pick best level, lowest index wins ties
   logic win_any;
   logic [2:0] win_src;
   logic [1:0] win_lvl;
   always_comb begin
      win_any = 1'b0;
      win_src = 3'h0;
      win_lvl = 2'h0;
      for (int i = 0; i < iep_pkg::NUM_SRC; i++) begin
         if (gated[i] && (!win_any || lvl[i] > win_lvl)) begin
            win_any = 1'b1;
            win_src = i[2:0];
            win_lvl = lvl[i];
         end
      end
   end

   // only a strictly higher level may preempt; an equal level waits
   // for the return, which keeps nesting depth to one slot per level
   wire preempt_ok = !run_any || (win_lvl > run_lvl);
   // limitation: the request still stands in the cycle after entry,
   // so the core must take it once and ignore that echo
   wire req_next = win_any && preempt_ok;

   // service-level bookkeeping: enter sets, return clears top
   // set after clear: an entry in the cycle of a return is kept
   always_comb begin
      active_next = active_reg;
      if (isr_return) begin
         active_next[run_lvl] = 1'b0;
      end
      if (isr_enter && irq_req_reg) begin
         active_next[irq_level_reg] = 1'b1;
      end
   end

   // registers; writes act on the next sampling cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         interrupt_mask_reg <= iep_pkg::MASK_RESET;
         priority_low_bits_reg <= iep_pkg::PRIO_RESET;
         priority_high_bits_reg <= iep_pkg::PRIO_RESET;
      end else begin
         interrupt_mask_reg <= interrupt_mask_next;
         priority_low_bits_reg <= priority_low_bits_next;
         priority_high_bits_reg <= priority_high_bits_next;
      end
   end

   // register checks: mask writes land, all three registers hold without a write
   chk_bit_write: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (sel_mask && sfr_bit_wr && !sfr_wr) |=>
      interrupt_mask_reg[$past(sfr_bit_sel)] == $past(sfr_bit_val))
      else $error("mask bit write lost");
   chk_mask_hold: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !(sel_mask && (sfr_wr || sfr_bit_wr)) |=> $stable(interrupt_mask_reg))
      else $error("mask changed without a write");
   chk_lo_hold: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !(sel_lo && (sfr_wr || sfr_bit_wr)) |=>
      $stable(priority_low_bits_reg))
      else $error("low priority bits changed without a write");
   chk_hi_hold: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !(sel_hi && (sfr_wr || sfr_bit_wr)) |=>
      $stable(priority_high_bits_reg))
      else $error("high priority bits changed without a write");
   // bit 7 of both priority registers always reads one
   chk_bit7_reads: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (sel_lo || sel_hi) |-> sfr_rdata[7])
      else $error("priority bit 7 not one");
   chk_mask_write: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (sel_mask && sfr_wr) |=> interrupt_mask_reg == $past(sfr_wdata))
      else $error("mask write lost");

   // sample and decode every cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_req_reg <= 1'b0;
         irq_src_reg <= 3'h0;
         irq_level_reg <= 2'h0;
         active_reg <= 4'h0;
      end else begin
         irq_req_reg <= req_next;
         irq_src_reg <= win_src;
         irq_level_reg <= win_lvl;
         active_reg <= active_next;
      end
   end

   assign irq_req = irq_req_reg;
   assign irq_src = irq_src_reg;
   assign irq_level = irq_level_reg;

   // request checks; all sample on the system clock
   chk_global_blocks: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !global_irq_gate |=> !irq_req)
      else $error("request with global gate off");
   // the source index is the winner of the cycle before
   chk_mask_needed: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      irq_req |-> $past(interrupt_mask_reg[win_src]))
      else $error("request from masked source");
   chk_pend_needed: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      irq_req |-> $past(pend[win_src]))
      else $error("request without pending flag");
   chk_top_level_hold: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      active_reg[iep_pkg::PRIO_TOP] |=> !irq_req)
      else $error("top level routine preempted");
   chk_decode_cycle: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (!run_any && win_any) |=> irq_req)
      else $error("pending not decoded in one cycle");
   chk_level_win: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      irq_req |-> irq_level == $past(lvl[win_src]))
      else $error("level mismatch");
   // entry steps: the core takes a standing request, then no return
   // follows for one cycle
   sequence s_take;
      isr_enter && irq_req_reg && !isr_return;
   endsequence
   sequence s_quiet;
      !isr_return;
   endsequence
   chk_enter_records: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_take |=> active_reg[$past(irq_level_reg)])
      else $error("entered level not recorded");
   // once the entry has settled only a strictly higher level may ask
   chk_no_retake: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_take ##1 s_quiet |=> (!irq_req || irq_level > $past(irq_level, 2)))
      else $error("equal or lower level preempted");
   chk_return_clears: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (isr_return && !isr_enter && run_any) |=> !active_reg[$past(run_lvl)])
      else $error("return left its level active");
endmodule : iep_ctrl

// ---- hdl/iep_pkg.sv ----
// constants for the interrupt enable and priority block
package iep_pkg;
   // register addresses on the special-function bus
   localparam logic [7:0] ADDR_PRIO_HI = 8'h84;
   localparam logic [7:0] ADDR_MASK = 8'hA8;
   localparam logic [7:0] ADDR_PRIO_LO = 8'hB8;
   // field positions in the mask register
   localparam int BIT_GLOBAL = 7;
   localparam int BIT_SPI = 6;
   localparam int BIT_TMR2 = 5;
   localparam int BIT_UART = 4;
   localparam int BIT_TMR1 = 3;
   localparam int BIT_EXT1 = 2;
   localparam int BIT_TMR0 = 1;
   localparam int BIT_EXT0 = 0;
   // source count and priority field width
   localparam int NUM_SRC = 7;
   localparam int PRIO_W = 2;
   // reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [6:0] PRIO_RESET = 7'h00;
   // unused bit 7 of the priority registers reads as one
   localparam logic UNUSED_READ = 1'b1;
   // highest level, never preempted
   localparam logic [1:0] PRIO_TOP = 2'h3;
   // service-stack depth: one slot per level
   localparam int STACK_D = 4;
   // fastest response: detect plus call
   localparam int MIN_RESPONSE_CYC = 5;
endpackage : iep_pkg

// ---- bench/iep_cpu_model.sv ----
// cpu side model: accepts a live request once per take command
`timescale 1ns/1ps
module iep_cpu_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // request from the block, command from the bench
   input wire logic irq_req,
   input wire logic take,
   // acceptance pulse back to the block
   output logic isr_enter
);
   logic done_reg; // one entry per take, avoids double acceptance
   // pulse only while a request stands, as a real core would
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         isr_enter <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         isr_enter <= take && irq_req && !done_reg;
         done_reg <= take && (done_reg || irq_req);
      end
   end
endmodule : iep_cpu_model

// ---- bench/test_iep_ctrl.sv ----
// self-checking bench for the enable and priority block
`timescale 1ns/1ps
module test_iep_ctrl;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, pnd = 8'h00, rd, m, lo, hi;
   logic wr = 1'b0, bw = 1'b0, bval = 1'b0, ret = 1'b0, take = 1'b0;
   logic [2:0] bsel = 3'h0, src;
   logic [1:0] lvl;
   logic [5:0] w;
   logic req, ent;
   int n_mismatch = 0, total_checks = 0;
   always #5 sys_clk = ~sys_clk;
   iep_ctrl DUT (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_addr(addr),
      .sfr_wr(wr), .sfr_wdata(wd), .sfr_bit_wr(bw), .sfr_bit_sel(bsel),
      .sfr_bit_val(bval), .sfr_rdata(rd), .ext_line_zero_input(pnd[0]),
      .timer_zero_overflow(pnd[1]), .ext_line_one_input(pnd[2]),
      .timer_one_overflow(pnd[3]), .uart_pending(pnd[4]),
      .timer_two_low_overflow(pnd[5]), .timer_two_high_overflow(pnd[6]),
      .spi_pending(pnd[7]), .isr_enter(ent), .isr_return(ret),
      .irq_req(req), .irq_src(src), .irq_level(lvl));
   iep_cpu_model CPU (.sys_clk(sys_clk), .arst_n(arst_n), .irq_req(req),
      .take(take), .isr_enter(ent));
   // compare and count
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      total_checks++;
      if (exp !== got) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // pass n edges, land just after the last one
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // byte write, or single-bit write of d[0] when b is set
   task automatic put(logic [7:0] a, logic [7:0] d, logic b, logic [2:0] s);
      addr = a;
      wd = d;
      wr = !b;
      bw = b;
      bsel = s;
      bval = d[0];
      tick(1);
      wr = 1'b0;
      bw = 1'b0;
      tick(1); // idle edge, so the next call never re-raises a strobe
   endtask : put
   // address set after an edge, data looked at after the next one
   task automatic get(logic [7:0] a, logic [7:0] e);
      addr = a;
      tick(1);
      chk("rdata", e, rd);
   endtask : get
   // winner: highest level, lowest index among equals
   function automatic logic [5:0] want(logic [7:0] mk, l, h, p);
      logic [6:0] act;
      logic [5:0] r;
      act = {p[7], p[6] | p[5], p[4:0]} & mk[6:0] & {7{mk[7]}};
      r = 6'h00;
      for (int i = 6; i >= 0; i--) begin
         if (act[i] && (!r[5] || {h[i], l[i]} >= r[1:0])) begin
            r = {1'b1, 3'(i), h[i], l[i]};
         end
      end
      return r;
   endfunction : want
   // verdict and end of run
   task automatic close_out();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   // hang guard, counted as a mismatch
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   // main sequence
   initial begin
      void'($urandom(17));
      tick(4);
      arst_n = 1'b1;
      get(8'hA8, 8'h00);
      get(8'hB8, 8'h80);
      get(8'h84, 8'h80);
      get(8'h55, 8'h00);
      put(8'hB8, 8'h01, 1'b1, 3'h7);
      get(8'hB8, 8'h80);
      put(8'hB8, 8'h01, 1'b1, 3'h2);
      get(8'hB8, 8'h84);
      put(8'h84, 8'h01, 1'b1, 3'h5);
      get(8'h84, 8'hA0);
      put(8'hA8, 8'h01, 1'b1, 3'h7);
      get(8'hA8, 8'h80);
      put(8'h55, 8'hFF, 1'b0, 3'h0);
      get(8'hA8, 8'h80);
      // random configurations; first two hit ties and the global gate
      for (int k = 0; k < 200; k++) begin
         m = (k < 2) ? {!k[0], 7'h7F} : 8'($urandom);
         lo = (k < 2) ? 8'h00 : 8'($urandom);
         hi = (k < 2) ? 8'h00 : 8'($urandom);
         pnd = (k < 2) ? 8'hFF : 8'($urandom);
         put(8'hA8, m, 1'b0, 3'h0);
         put(8'hB8, lo, 1'b0, 3'h0);
         put(8'h84, hi, 1'b0, 3'h0);
         get(8'hB8, lo | 8'h80);
         get(8'h84, hi | 8'h80);
         tick(1);
         w = want(m, lo, hi, pnd);
         chk("irq", {2'h0, w}, {2'h0, req, w[5] ? {src, lvl} : 5'h00});
      end
      // preemption: async serial at level 0, then line zero at level 3
      pnd = 8'h10;
      put(8'hB8, 8'h01, 1'b0, 3'h0);
      put(8'h84, 8'h01, 1'b0, 3'h0);
      put(8'hA8, 8'h91, 1'b0, 3'h0);
      tick(1);
      chk("irq", 8'h30, {2'h0, req, src, lvl});
      take = 1'b1;
      tick(3);
      take = 1'b0;
      chk("busy", 8'h00, {7'h0, req});
      pnd = 8'h11;
      tick(2);
      chk("irq", 8'h23, {2'h0, req, src, lvl});
      take = 1'b1;
      tick(3);
      take = 1'b0;
      chk("busy", 8'h00, {7'h0, req});
      ret = 1'b1;
      tick(1);
      ret = 1'b0;
      tick(2);
      chk("irq", 8'h23, {2'h0, req, src, lvl});
      close_out();
   end
endmodule : test_iep_ctrl
